/* File: hsq_pkg.sv */
// package of constants and state types for the hot-swap rail sequencer
package hsq_pkg;
	localparam int NUM_CH = 4;
	// channel index order is also the ramp-up order
	localparam int CH_12V = 0;
	localparam int CH_5V = 1;
	localparam int CH_3V3 = 2;
	localparam int CH_NEG12V = 3;
	localparam int LAST_CH = NUM_CH - 1;
	// slot enable filter time and its cycle count at the reference clock
	localparam int CLK_FREQ_HZ = 25000000;
	localparam int ENABLE_FILTER_US = 100;
	localparam int ENABLE_FILTER_CYCLES = ENABLE_FILTER_US * (CLK_FREQ_HZ / 1000000);
	localparam int FILT_W = 12;
	localparam logic [FILT_W-1:0] FILT_ZERO = 12'h000;
	localparam logic [FILT_W-1:0] FILT_ONE = 12'h001;
	localparam logic [1:0] CH_ZERO = 2'h0;
	localparam logic [1:0] CH_ONE = 2'h1;
	localparam logic [1:0] CH_LAST = 2'h3;
	localparam logic [NUM_CH-1:0] GATES_OFF = 4'h0;
	typedef enum logic [2:0] {
		HSQ_SLEEP,
		HSQ_CHECK_IN,
		HSQ_RAMP,
		HSQ_HEALTHY,
		HSQ_RAMP_DOWN,
		HSQ_FAULT
	} hsq_state_type;
endpackage

/* File: hsq_filter.sv */
// digital filter for the active-low slot enable input
`timescale 1ns/100ps
module hsq_filter #(
	parameter int FILT_CYCLES = hsq_pkg::ENABLE_FILTER_CYCLES
) (
	input  wire logic ref_clk_i,    // reference clock
	input  wire logic rst_i,        // async reset, active high
	input  wire logic raw_n_i,      // raw slot enable, active low
	output logic      filt_n_o      // filtered slot enable
);
	typedef struct packed {
		logic                           level;
		logic [hsq_pkg::FILT_W-1:0]     count;
	} hsq_filt_type;

	hsq_filt_type st_reg;
	hsq_filt_type st_next;

	// a change must hold for the whole window, either direction
	always_comb begin
		st_next = st_reg;
		if (raw_n_i == st_reg.level) begin
			st_next.count = hsq_pkg::FILT_ZERO;
		end else if (st_reg.count == hsq_pkg::FILT_W'(FILT_CYCLES - 1)) begin
			st_next.level = raw_n_i;
			st_next.count = hsq_pkg::FILT_ZERO;
		end else begin
			st_next.count = st_reg.count + hsq_pkg::FILT_ONE;
		end
	end

	// resets to deasserted so the rails stay off until a real low arrives
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= '{level: 1'b1, count: hsq_pkg::FILT_ZERO};
		end else begin
			st_reg <= st_next;
		end
	end

	assign filt_n_o = st_reg.level;

	chk_filter_stable: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(raw_n_i == filt_n_o) |=> $stable(filt_n_o)) else $error("filter moved without input change");
endmodule

/* File: hsq_sequencer.sv */
// hot-swap rail sequencer: ordered ramp, fault latch, power-good output
// Overview of operation
// - with inputs good and slot enable low, the rails ramp up one after another.
// - slot enable high turns every back-end rail off and the block goes to sleep.
// - power-good is open drain, pulled low only when all rails are good, else released.
// - power-good is false when power is off, a rail is out of window, overcurrent or timeout.
// - each channel's input is checked for undervoltage before it ramps, and is not ramped if low.
// - each ramp ends at its timer expiry, after which the load rail is watched continuously.
// - channels come up one at a time in the order 12 V, 5 V, 3.3 V, -12 V.
// - outside healthy and ramp-down, slot enable high holds all four gate drives off.
// - before each ramp, that channel's input is checked against undervoltage and all four inputs against overvoltage.
// - a channel that hits peak current finishes charging at that fixed limit.
// - an overcurrent on any gated channel turns all rails off and latches them until slot enable toggles or reset.
// - slot enable high while healthy ramps rails off one by one in reverse order, then sleeps.
// - slot enable is filtered for 100 us on both edges before any change is acted on.
`timescale 1ns/100ps
module hsq_sequencer #(
	parameter int NUM_CH      = hsq_pkg::NUM_CH,
	parameter int FILT_CYCLES = hsq_pkg::ENABLE_FILTER_CYCLES
) (
	input  wire logic              ref_clk_i,          // 25 MHz reference clock
	input  wire logic              rst_i,              // supply lockout reset, active high
	input  wire logic              slot_enable_n_i,    // backplane slot enable, active low
	input  wire logic [NUM_CH-1:0] input_uv_i,         // input rail below undervoltage limit
	input  wire logic [NUM_CH-1:0] input_ov_i,         // input rail above overvoltage limit
	input  wire logic [NUM_CH-1:0] backend_uv_i,       // load rail below undervoltage limit
	input  wire logic [NUM_CH-1:0] backend_ov_i,       // load rail above overvoltage limit
	input  wire logic [NUM_CH-1:0] overcurrent_i,      // circuit breaker trip per channel
	input  wire logic [NUM_CH-1:0] peak_limit_i,       // charge current reached peak limit
	input  wire logic [NUM_CH-1:0] ramp_expired_i,     // ramp timer expiry per channel
	output logic [NUM_CH-1:0]      pass_fet_drive_o,   // gate enable, bit 0 is 12 V
	output logic [NUM_CH-1:0]      fixed_limit_o,      // charge at fixed peak limit
	output logic [NUM_CH-1:0]      ramp_start_o,       // one-cycle pulse: start channel timer
	output logic                   power_good_n_o,     // open-drain output value, always 0
	output logic                   power_good_oe_n_o,  // low while pulling power-good low
	output logic                   sleep_o             // low-power sleep indication
);
	typedef struct packed {
		hsq_pkg::hsq_state_type state;
		logic [1:0]             ch;
		logic [NUM_CH-1:0]      gates;
		logic [NUM_CH-1:0]      fixed;
		logic [NUM_CH-1:0]      start;
		logic [NUM_CH-1:0]      done;
		logic                   good;
	} hsq_seq_type;

	hsq_seq_type st_reg;
	hsq_seq_type st_next;
	logic        enable_n;
	logic [NUM_CH-1:0] done_bad;
	logic        any_oc;

	hsq_filter #(
		.FILT_CYCLES (FILT_CYCLES)
	) u_filter (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.raw_n_i   (slot_enable_n_i),
		.filt_n_o  (enable_n)
	);

	// rails already ramped are watched continuously against their window
	assign done_bad = st_reg.done & (backend_uv_i | backend_ov_i);
	assign any_oc   = |(overcurrent_i & st_reg.gates);

	// sequencing state machine
	always_comb begin
		st_next       = st_reg;
		st_next.start = hsq_pkg::GATES_OFF;
		st_next.good  = 1'b0;
		// peak current reached: stay at the fixed limit until the channel is done
		st_next.fixed = st_reg.fixed | (peak_limit_i & st_reg.gates & ~st_reg.done);
		unique case (st_reg.state)
			hsq_pkg::HSQ_SLEEP: begin
				st_next.gates = hsq_pkg::GATES_OFF;
				st_next.done  = hsq_pkg::GATES_OFF;
				st_next.fixed = hsq_pkg::GATES_OFF;
				st_next.ch    = hsq_pkg::CH_ZERO;
				if (!enable_n && !(|input_uv_i)) begin
					st_next.state = hsq_pkg::HSQ_CHECK_IN;
				end
			end
			hsq_pkg::HSQ_CHECK_IN: begin
				// ramp only a channel whose input is in window; wait otherwise
				if (!input_uv_i[st_reg.ch] && !(|input_ov_i)) begin
					st_next.gates[st_reg.ch] = 1'b1;
					st_next.start[st_reg.ch] = 1'b1;
					st_next.state            = hsq_pkg::HSQ_RAMP;
				end
			end
			hsq_pkg::HSQ_RAMP: begin
				if (ramp_expired_i[st_reg.ch]) begin
					if (backend_uv_i[st_reg.ch] || backend_ov_i[st_reg.ch]) begin
						// timeout into a faulted load
						st_next.state = hsq_pkg::HSQ_FAULT;
						st_next.gates = hsq_pkg::GATES_OFF;
					end else begin
						st_next.done[st_reg.ch]  = 1'b1;
						st_next.fixed[st_reg.ch] = 1'b0;
						if (st_reg.ch == hsq_pkg::CH_LAST) begin
							st_next.state = hsq_pkg::HSQ_HEALTHY;
						end else begin
							st_next.ch    = st_reg.ch + hsq_pkg::CH_ONE;
							st_next.state = hsq_pkg::HSQ_CHECK_IN;
						end
					end
				end
			end
			hsq_pkg::HSQ_HEALTHY: begin
				st_next.good = ~(|done_bad);
				if (enable_n) begin
					st_next.good  = 1'b0;
					st_next.ch    = hsq_pkg::CH_LAST;
					st_next.gates[hsq_pkg::CH_LAST] = 1'b0;
					st_next.done[hsq_pkg::CH_LAST]  = 1'b0;
					st_next.state = hsq_pkg::HSQ_RAMP_DOWN;
				end
			end
			hsq_pkg::HSQ_RAMP_DOWN: begin
				// one rail per cycle in reverse order
				if (st_reg.ch == hsq_pkg::CH_ZERO) begin
					st_next.state = hsq_pkg::HSQ_SLEEP;
				end else begin
					st_next.ch = st_reg.ch - hsq_pkg::CH_ONE;
					st_next.gates[st_reg.ch - hsq_pkg::CH_ONE] = 1'b0;
					st_next.done[st_reg.ch - hsq_pkg::CH_ONE]  = 1'b0;
				end
			end
			hsq_pkg::HSQ_FAULT: begin
				// latched off; only a filtered high on slot enable releases it
				st_next.gates = hsq_pkg::GATES_OFF;
				st_next.done  = hsq_pkg::GATES_OFF;
				st_next.fixed = hsq_pkg::GATES_OFF;
				if (enable_n) begin
					st_next.state = hsq_pkg::HSQ_SLEEP;
				end
			end
		endcase
		// overcurrent beats every other event, even ramp-down
		if (any_oc) begin
			st_next.state = hsq_pkg::HSQ_FAULT;
			st_next.gates = hsq_pkg::GATES_OFF;
			st_next.done  = hsq_pkg::GATES_OFF;
			st_next.fixed = hsq_pkg::GATES_OFF;
			st_next.good  = 1'b0;
		end else if (enable_n && st_reg.state != hsq_pkg::HSQ_HEALTHY
				&& st_reg.state != hsq_pkg::HSQ_RAMP_DOWN) begin
			// power removal outside healthy and ramp-down: everything off at once
			st_next.state = hsq_pkg::HSQ_SLEEP;
			st_next.gates = hsq_pkg::GATES_OFF;
			st_next.done  = hsq_pkg::GATES_OFF;
			st_next.fixed = hsq_pkg::GATES_OFF;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= '{state: hsq_pkg::HSQ_SLEEP, ch: hsq_pkg::CH_ZERO,
				gates: hsq_pkg::GATES_OFF, fixed: hsq_pkg::GATES_OFF,
				start: hsq_pkg::GATES_OFF, done: hsq_pkg::GATES_OFF, good: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from state flip-flops
	assign pass_fet_drive_o  = st_reg.gates;
	assign fixed_limit_o     = st_reg.fixed;
	assign ramp_start_o      = st_reg.start;
	assign power_good_n_o    = 1'b0;
	assign power_good_oe_n_o = ~st_reg.good;
	assign sleep_o           = (st_reg.state == hsq_pkg::HSQ_SLEEP);

	chk_gates_off_disabled: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(enable_n && st_reg.state != hsq_pkg::HSQ_HEALTHY
			&& st_reg.state != hsq_pkg::HSQ_RAMP_DOWN) |=> ($past(st_reg.state)
			== hsq_pkg::HSQ_FAULT || pass_fet_drive_o == hsq_pkg::GATES_OFF))
		else $error("gates on while slot disabled");
	chk_oc_latch_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		any_oc |=> (pass_fet_drive_o == hsq_pkg::GATES_OFF) && power_good_oe_n_o
			&& st_reg.state == hsq_pkg::HSQ_FAULT) else $error("overcurrent did not latch off");
	chk_fault_held: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(st_reg.state == hsq_pkg::HSQ_FAULT && !enable_n) |=>
			st_reg.state == hsq_pkg::HSQ_FAULT) else $error("fault latch released early");
	chk_good_only_healthy: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!power_good_oe_n_o |-> $past(st_reg.state) == hsq_pkg::HSQ_HEALTHY
			&& pass_fet_drive_o == {NUM_CH{1'b1}}) else $error("power good without all rails");
	chk_good_window: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(|done_bad) |=> power_good_oe_n_o) else $error("power good with rail out of window");
	chk_one_at_time: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		($countones(ramp_start_o) <= 1) and ((ramp_start_o != hsq_pkg::GATES_OFF) |->
			pass_fet_drive_o == ((ramp_start_o << 1) - 1'b1))) else $error("ramp order broken");
	chk_no_ramp_uv: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(st_reg.state == hsq_pkg::HSQ_CHECK_IN && input_uv_i[st_reg.ch] && !any_oc
			&& !enable_n) |=> st_reg.state == hsq_pkg::HSQ_CHECK_IN)
		else $error("ramped a channel with low input");
	chk_reverse_down: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(st_reg.state == hsq_pkg::HSQ_HEALTHY && enable_n && !any_oc) |=>
			pass_fet_drive_o == 4'h7 ##1 ($past(any_oc) || pass_fet_drive_o == 4'h3))
		else $error("ramp down not in reverse order");
	chk_fixed_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(st_reg.state == hsq_pkg::HSQ_RAMP && peak_limit_i[st_reg.ch] && !any_oc && !enable_n
			&& !ramp_expired_i[st_reg.ch]) |=> fixed_limit_o[$past(st_reg.ch)])
		else $error("peak limit not held");
endmodule

/* File: hsq_rail_model.sv */
// load-side rails and ramp timers that face the sequencer's gate outputs
`timescale 1ns/100ps
module hsq_rail_model (
	input  wire logic       ref_clk_i,   // reference clock
	input  wire logic [3:0] gate_i,      // gate enables from the sequencer
	input  wire logic [3:0] start_i,     // ramp timer start pulses
	input  wire logic [3:0] stuck_uv_i,  // rail that never reaches its window
	input  wire logic [3:0] ov_i,        // rail forced above its window
	input  wire logic [7:0] dly_i,       // ramp time in cycles, at least 2
	output logic [3:0]      expired_o,   // one-cycle timer expiry
	output logic [3:0]      uv_o,        // load rail below window
	output logic [3:0]      ov_o         // load rail above window
);
	int cnt [4];
	// a rail whose gate is off carries no voltage, so it reads undervoltage
	always @(posedge ref_clk_i) begin
		for (int i = 0; i < 4; i++) begin
			expired_o[i] <= (cnt[i] == 1);
			cnt[i] <= start_i[i] ? int'(dly_i) : (cnt[i] > 0 ? cnt[i] - 1 : 0);
		end
		uv_o <= ~gate_i | stuck_uv_i;
		ov_o <= ov_i;
	end
endmodule

/* File: tb.sv */
// self-checking bench for the hot-swap rail sequencer
`timescale 1ns/100ps
module tb;
	localparam int FILT = 8;  // short enable filter keeps the run brief
	logic       clk = 1'h0;
	logic       rst = 1'h1;
	logic       slot_n = 1'h1;
	logic [3:0] in_uv = 4'h0, in_ov = 4'h0, oc = 4'h0, pk = 4'h0, stuck = 4'h0, fov = 4'h0;
	logic [7:0] dly = 8'h04;
	logic [3:0] gate, fixd, rstart, exp_d, buv, bov, gp = 4'h0;
	logic       pg_n, pg_oe_n, slp;
	int         fail_count = 0, n_tests = 0, sc = 0, k;
	logic [3:0] gq[$];
	wire        pg_line = pg_oe_n ? 1'h1 : pg_n;  // pulled up while released
	always #20 clk = ~clk;
	hsq_sequencer #(.NUM_CH(4), .FILT_CYCLES(FILT)) uut (
		.ref_clk_i(clk), .rst_i(rst), .slot_enable_n_i(slot_n), .input_uv_i(in_uv),
		.input_ov_i(in_ov), .backend_uv_i(buv), .backend_ov_i(bov), .overcurrent_i(oc),
		.peak_limit_i(pk), .ramp_expired_i(exp_d), .pass_fet_drive_o(gate),
		.fixed_limit_o(fixd), .ramp_start_o(rstart), .power_good_n_o(pg_n),
		.power_good_oe_n_o(pg_oe_n), .sleep_o(slp));
	hsq_rail_model rails (.ref_clk_i(clk), .gate_i(gate), .start_i(rstart),
		.stuck_uv_i(stuck), .ov_i(fov), .dly_i(dly), .expired_o(exp_d), .uv_o(buv),
		.ov_o(bov));
	// log each change of the gate pattern and count timer starts
	always @(posedge clk) begin
		if (gate !== gp)
			gq.push_back(gate);
		gp = gate;
		sc += $countones(rstart);
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] want, input string what);
		n_tests++;
		if (got !== want) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask
	// rising fills from the 12 V channel upward, falling empties from the top
	task automatic chk_seq(input bit up);
		int e;
		e = up ? 0 : 15;
		chk(4'(gq.size()), 4'h4, "gate steps");
		for (int i = 0; i < 4; i++) begin
			e = up ? (e | (1 << i)) : (e & ~(1 << (3 - i)));
			chk(gq[i], 4'(e), "gate pattern");
		end
	endtask
	task automatic power_up();
		gq.delete();
		sc = 0;
		dly <= 8'(2 + $urandom % 19);
		slot_n <= 1'h0;
		for (int i = 0; i < 400 && pg_line !== 1'h0; i++) @(posedge clk);
		cyc(1);
		chk(pg_line, 4'h0, "power good");
		chk_seq(1);
		chk(4'(sc), 4'h4, "timer starts");
		chk(slp, 4'h0, "awake");
	endtask
	task automatic power_down();
		gq.delete();
		slot_n <= 1'h1;
		for (int i = 0; i < 100 && slp !== 1'h1; i++) @(posedge clk);
		cyc(1);
		chk(gate, 4'h0, "gates off");
		chk(pg_line, 4'h1, "power good off");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		void'($urandom(74));
		cyc(10);
		rst <= 1'h0;
		cyc(2);
		chk(gate, 4'h0, "reset gates");
		chk(pg_line, 4'h1, "reset power good");
		chk(slp, 4'h1, "reset sleep");
		// a low pulse one cycle shorter than the filter must change nothing
		gq.delete();
		slot_n <= 1'h0;
		cyc(FILT - 1);
		slot_n <= 1'h1;
		cyc(20);
		chk(gate, 4'h0, "glitch");
		chk(4'(gq.size()), 4'h0, "glitch gate steps");
		chk(slp, 4'h1, "glitch sleep");
		$display("test filter done");
		// an input rail out of limits keeps every gate off until it recovers
		for (int m = 0; m < 2; m++) begin
			k = $urandom % 4;
			if (m == 0)
				in_uv[k] <= 1'h1;
			else
				in_ov[k] <= 1'h1;
			slot_n <= 1'h0;
			cyc(40);
			chk(gate, 4'h0, "input fault");
			in_uv <= 4'h0;
			in_ov <= 4'h0;
			power_up();
			power_down();
			chk_seq(0);
			$display("test input limits done");
		end
		// load rail leaves its window while healthy, then an overcurrent trip
		power_up();
		k = $urandom % 4;
		fov[k] <= 1'h1;
		cyc(4);
		chk(pg_line, 4'h1, "window");
		fov <= 4'h0;
		cyc(4);
		chk(pg_line, 4'h0, "window back");
		oc[$urandom % 4] <= 1'h1;
		cyc(3);
		oc <= 4'h0;
		cyc(20);
		chk(gate, 4'h0, "breaker latch");
		chk(pg_line, 4'h1, "breaker power good");
		power_down();
		power_up();
		power_down();
		$display("test faults done");
		// peak current on the first channel, then a rail that never comes up
		dly <= 8'h14;
		stuck[1] <= 1'h1;
		slot_n <= 1'h0;
		for (int i = 0; i < 100 && gate[0] !== 1'h1; i++) @(posedge clk);
		pk[0] <= 1'h1;
		cyc(3);
		chk(fixd[0], 4'h1, "fixed limit");
		pk <= 4'h0;
		// an input that sags after the sequence has begun holds that channel back
		in_uv[1] <= 1'h1;
		cyc(40);
		chk(gate, 4'h1, "channel input low");
		in_uv <= 4'h0;
		for (int i = 0; i < 100 && gate[1] !== 1'h1; i++) @(posedge clk);
		cyc(30);
		chk(gate, 4'h0, "ramp timeout");
		stuck <= 4'h0;
		power_down();
		$display("test timeout done");
		final_report();
	end
	// cut a hang short well beyond the expected run length
	initial begin
		cyc(20000);
		fail_count++;
		final_report();
	end
endmodule
